// [logic/fault_sup_map.vh]
// Constants for the drive fault supervisor: fault indices, display codes, timing.
// Assumes inclusion by the supervisor module only.
`ifndef FAULT_SUP_MAP_VH
`define FAULT_SUP_MAP_VH

// ----------------------------------------
// Fault indices, highest priority first
// ----------------------------------------
`define F_PUTEST 0
`define F_NVM 1
`define F_DOVT 2
`define F_CFG 3
`define F_PMOD 4
`define F_HBUS 5
`define F_LBUS 6
`define F_ENCST 7
`define F_ENCHW 8
`define F_MOVT 9
`define F_SHUNT 10
`define F_OSPD 11
`define F_FERR 12
`define F_TRAV 13
`define F_ALLON 14
`define NFAULT 15

// ----------------------------------------
// Display codes
// ----------------------------------------
`define DISP_FAULT_BASE 5'h10
`define DISP_DISABLED 5'h01
`define DISP_PULSE 5'h02
`define DISP_VEL 5'h03
`define DISP_TORQ 5'h04
`define DISP_SUM 5'h05
`define DISP_RMS_FB 5'h06
`define DISP_STALL_FB 5'h07
`define DISP_BRAKE 5'h08

// ----------------------------------------
// Operating mode encodings
// ----------------------------------------
`define MODE_PULSE 3'h0
`define MODE_VEL 3'h1
`define MODE_TORQ 3'h2
`define MODE_SUM 3'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 100000000
`define LBUS_DEB_MS 50
`define CFG_HOLD_S 10
`define ALLON_MS 1000
`define FOLDBACK_PCT 80

// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define OFF_STATUS 4'h0
`define OFF_MASK 4'h1
`define OFF_ACTIVE 4'h2
`define OFF_CTRL 4'h3
`define RST_MASK 16'h0000
`define RST_CTRL 8'h00

`endif

// [logic/drive_fault_supervisor.v]
// Drive fault supervisor: latches protection faults, picks the display code,
// gates the bridge and motion, tracks position and raises one interrupt.
// Assumes a 100 MHz clock; fault and button pins arrive asynchronously.
`timescale 1ns/1ns
`include "fault_sup_map.vh"

// Function
// - Active fault code overrides status display.
// - Ready dot when enabled and no stop.
// - Motion only while ready.
// - Brake character only if assigned and off.
// - RMS foldback limits torque to 80 percent.
// - Stall foldback limits current 80 percent.
// - Fixed fault priority order.
// - Display only highest active fault.
// - Resettable faults clear on reset request.
// - Power-cycle faults ignore reset requests.
// - Travel limit auto clears, keeps bridge.
// - Position counter tracks during faults.
// - Self-test failure unresettable top fault.
// - Memory check failure raises memory fault.
// - Config fault clears on 10 s hold.
// - All segments lit about 1 s, bridge off.
// - Low bus debounced 50 ms.
module drive_fault_supervisor #(
  parameter VARIANT_STALL = 1,
  parameter LBUS_CYC = (`CLK_HZ / 1000) * `LBUS_DEB_MS,
  parameter CFG_HOLD_CYC = `CLK_HZ * `CFG_HOLD_S,
  parameter ALLON_CYC = (`CLK_HZ / 1000) * `ALLON_MS,
  parameter POS_W = 32
) (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire selftest_fail,
  input wire nvm_invalid,
  input wire drive_ovt,
  input wire module_seen,
  input wire pmod_flt,
  input wire high_bus,
  input wire low_bus,
  input wire enc_state_err,
  input wire enc_hw_err,
  input wire motor_ovt,
  input wire shunt_ovl,
  input wire overspeed,
  input wire follow_err,
  input wire travel_pos,
  input wire travel_neg,
  input wire reset_button,
  input wire reset_input,
  input wire drive_enable,
  input wire stop_input,
  input wire [2:0] op_mode,
  input wire rms_foldback,
  input wire stall_foldback,
  input wire brake_assigned,
  input wire brake_out_on,
  input wire motion_req,
  input wire enc_step,
  input wire enc_dir,
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  output reg [4:0] display_code,
  output reg ready_dot,
  output wire motion_en,
  output reg bridge_disable,
  output reg all_segments,
  output reg limit_80,
  output reg [POS_W-1:0] position,
  output wire irq
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Every pin from outside the clock domain passes three flip-flops. The
  // qualified copy follows the third stage while the second and third stages
  // agree and clears while they differ, so a single-cycle glitch on a fault
  // line never reaches the latches. Only the second stage reads the first.
  localparam NIN = 21;
  wire [NIN-1:0] raw_in;
  reg [NIN-1:0] s1_reg;
  reg [NIN-1:0] s2_reg;
  reg [NIN-1:0] s3_reg;
  reg [NIN-1:0] in_reg;
  assign raw_in = {enc_dir, enc_step, brake_out_on, reset_input, reset_button,
                   travel_neg, travel_pos, follow_err, overspeed, shunt_ovl,
                   motor_ovt, enc_hw_err, enc_state_err, low_bus, high_bus,
                   pmod_flt, module_seen, drive_ovt, nvm_invalid, selftest_fail,
                   stop_input};

  always @(posedge clk) begin
    if (!resetn) begin
      s1_reg <= {NIN{1'b0}};
      s2_reg <= {NIN{1'b0}};
      s3_reg <= {NIN{1'b0}};
      in_reg <= {NIN{1'b0}};
    end else if (ce) begin
      s1_reg <= raw_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      in_reg <= (in_reg & ~(s2_reg ^ s3_reg)) | (s3_reg & ~(s2_reg ^ s3_reg));
    end
  end

  wire stop_s = in_reg[0];
  wire st_s = in_reg[1];
  wire nvm_s = in_reg[2];
  wire dovt_s = in_reg[3];
  wire mod_s = in_reg[4];
  wire pmod_s = in_reg[5];
  wire hbus_s = in_reg[6];
  wire lbus_s = in_reg[7];
  wire encst_s = in_reg[8];
  wire enchw_s = in_reg[9];
  wire movt_s = in_reg[10];
  wire shunt_s = in_reg[11];
  wire ospd_s = in_reg[12];
  wire ferr_s = in_reg[13];
  wire trav_s = in_reg[14] | in_reg[15];
  wire rbtn_s = in_reg[16];
  wire rin_s = in_reg[17];
  wire brake_on_s = in_reg[18];
  wire step_s = in_reg[19];
  wire dir_s = in_reg[20];

  // ----------------------------------------
  // Power-up sequence and timers
  // ----------------------------------------
  // The lamp test holds the display lit and the bridge off from reset release.
  // The low-bus counter restarts whenever the pin drops, so short dips never trip.
  // The hold counter stops at its end value until the button is released.
  reg allon_reg;
  reg [31:0] allon_cnt_reg;
  reg [31:0] lbus_cnt_reg;
  reg [31:0] hold_cnt_reg;
  reg rbtn_d_reg;
  reg rin_d_reg;
  wire lbus_trip = (lbus_cnt_reg == LBUS_CYC[31:0] - 32'h1) & lbus_s;
  wire hold_done = (hold_cnt_reg == CFG_HOLD_CYC[31:0] - 32'h1) & rbtn_s;
  // A reset request is the rising edge of either the button or the input line.
  wire rst_req = (rbtn_s & ~rbtn_d_reg) | (rin_s & ~rin_d_reg);

  always @(posedge clk) begin
    if (!resetn) begin
      allon_reg <= 1'b1;
      allon_cnt_reg <= 32'h0;
      lbus_cnt_reg <= 32'h0;
      hold_cnt_reg <= 32'h0;
      rbtn_d_reg <= 1'b0;
      rin_d_reg <= 1'b0;
    end else if (ce) begin
      rbtn_d_reg <= rbtn_s;
      rin_d_reg <= rin_s;
      if (allon_reg) begin
        if (allon_cnt_reg == ALLON_CYC[31:0] - 32'h1)
          allon_reg <= 1'b0;
        else
          allon_cnt_reg <= allon_cnt_reg + 32'h1;
      end
      if (!lbus_s || lbus_trip)
        lbus_cnt_reg <= 32'h0;
      else
        lbus_cnt_reg <= lbus_cnt_reg + 32'h1;
      if (!rbtn_s)
        hold_cnt_reg <= 32'h0;
      else if (!hold_done)
        hold_cnt_reg <= hold_cnt_reg + 32'h1;
    end
  end

  // ----------------------------------------
  // Fault latches
  // ----------------------------------------
  // A latch is set while its detector is high and a clear in the same cycle
  // loses, so a fault whose detector stays high survives every reset request.
  // Motor overtemp clears only once its source has gone, that is after cooling.
  reg [`NFAULT-1:0] fault_reg;
  reg [`NFAULT-1:0] det;
  reg [`NFAULT-1:0] clr;
  always @* begin
    det = {`NFAULT{1'b0}};
    det[`F_PUTEST] = st_s;
    det[`F_NVM] = nvm_s;
    det[`F_DOVT] = dovt_s;
    det[`F_CFG] = mod_s;
    det[`F_PMOD] = pmod_s;
    det[`F_HBUS] = hbus_s;
    det[`F_LBUS] = lbus_trip;
    det[`F_ENCST] = encst_s;
    det[`F_ENCHW] = enchw_s;
    det[`F_MOVT] = movt_s;
    det[`F_SHUNT] = shunt_s;
    det[`F_OSPD] = ospd_s;
    det[`F_FERR] = ferr_s;
    det[`F_TRAV] = trav_s;
    det[`F_ALLON] = allon_reg;
    clr = {`NFAULT{1'b0}};
    clr[`F_NVM] = rst_req;
    clr[`F_HBUS] = rst_req;
    clr[`F_LBUS] = rst_req;
    clr[`F_MOVT] = rst_req & ~movt_s;
    clr[`F_SHUNT] = rst_req;
    clr[`F_OSPD] = rst_req;
    clr[`F_FERR] = rst_req;
    // The power module fault is resettable on the variant with stall foldback
    // and needs a power cycle on the other one.
    // power cycle only on the variant without stall foldback
    clr[`F_PMOD] = (VARIANT_STALL != 0) & rst_req;
    clr[`F_CFG] = hold_done;
    clr[`F_TRAV] = ~trav_s;
    clr[`F_ALLON] = ~allon_reg;
  end

  always @(posedge clk) begin
    if (!resetn)
      fault_reg <= {`NFAULT{1'b0}};
    else if (ce)
      fault_reg <= det | (fault_reg & ~clr);
  end

  // ----------------------------------------
  // Priority select and display
  // ----------------------------------------
  // The lamp-test request joins the latched faults here, so the display and
  // the bridge follow it from the first cycle after reset instead of one
  // cycle later, when its latch has caught up.
  wire [`NFAULT-1:0] flt_view;
  reg [3:0] top_idx;
  integer i;
  assign flt_view = fault_reg | ({{(`NFAULT-1){1'b0}}, allon_reg} << `F_ALLON);
  // The loop runs from the lowest priority upwards, so the last hit wins.
  // priority order
  always @* begin
    top_idx = 4'hf;
    for (i = `NFAULT - 1; i >= 0; i = i - 1)
      if (flt_view[i])
        top_idx = i[3:0];
  end

  wire any_fault = |flt_view;
  wire ready = drive_enable & ~stop_s & ~bridge_disable;
  wire stall_fb = (VARIANT_STALL != 0) & stall_foldback;

  always @(posedge clk) begin
    if (!resetn) begin
      display_code <= `DISP_DISABLED;
      ready_dot <= 1'b0;
      bridge_disable <= 1'b1;
      all_segments <= 1'b1;
      limit_80 <= 1'b0;
    end else if (ce) begin
      bridge_disable <= |(flt_view & ~({{(`NFAULT-1){1'b0}}, 1'b1} << `F_TRAV));
      all_segments <= allon_reg;
      // The dot shows enable and stop alone; the motion gate also needs the
      // bridge on.
      // ready dot
      ready_dot <= drive_enable & ~stop_s;
      limit_80 <= rms_foldback | stall_fb;
      if (any_fault)
        display_code <= `DISP_FAULT_BASE | {1'b0, top_idx};
      else if (rms_foldback)
        display_code <= `DISP_RMS_FB;
      else if (stall_fb)
        display_code <= `DISP_STALL_FB;
      else if (brake_assigned && !brake_on_s)
        display_code <= `DISP_BRAKE;
      else if (!drive_enable)
        display_code <= `DISP_DISABLED;
      else begin
        case (op_mode)
          `MODE_PULSE: display_code <= `DISP_PULSE;
          `MODE_VEL: display_code <= `DISP_VEL;
          `MODE_TORQ: display_code <= `DISP_TORQ;
          `MODE_SUM: display_code <= `DISP_SUM;
          default: display_code <= `DISP_DISABLED;
        endcase
      end
    end
  end

  // Motion requests pass only while the drive is enabled, no stop is present
  // and the bridge is on.
  // motion gate
  assign motion_en = motion_req & ready;

  // ----------------------------------------
  // Position tracking
  // ----------------------------------------
  // Step edges are counted whatever the fault state, so the position stays
  // true while the bridge is off.
  reg step_d_reg;
  always @(posedge clk) begin
    if (!resetn) begin
      position <= {POS_W{1'b0}};
      step_d_reg <= 1'b0;
    end else if (ce) begin
      step_d_reg <= step_s;
      if (step_s && !step_d_reg)
        position <= dir_s ? position - {{(POS_W-1){1'b0}}, 1'b1}
                          : position + {{(POS_W-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------
  // Registers and interrupt
  // ----------------------------------------
  // Status bit i records a rising edge of fault i and is cleared by writing
  // a one; an event in the same cycle as the clear wins. Read data stand for
  // one cycle after the strobe and are zero otherwise.
  reg [15:0] status_reg;
  reg [15:0] mask_reg;
  reg [7:0] ctrl_reg;
  reg [`NFAULT-1:0] fault_d_reg;
  wire [15:0] new_ev = {1'b0, fault_reg & ~fault_d_reg};

  always @(posedge clk) begin
    if (!resetn) begin
      status_reg <= 16'h0000;
      mask_reg <= `RST_MASK;
      ctrl_reg <= `RST_CTRL;
      fault_d_reg <= {`NFAULT{1'b0}};
      rdata <= 16'h0000;
    end else if (ce) begin
      fault_d_reg <= fault_reg;
      if (wr && addr == `OFF_STATUS)
        status_reg <= (status_reg & ~wdata) | new_ev;
      else
        status_reg <= status_reg | new_ev;
      if (wr && addr == `OFF_MASK)
        mask_reg <= wdata;
      if (wr && addr == `OFF_CTRL)
        ctrl_reg <= wdata[7:0];
      if (rd) begin
        case (addr)
          `OFF_STATUS: rdata <= status_reg;
          `OFF_MASK: rdata <= mask_reg;
          `OFF_ACTIVE: rdata <= {1'b0, fault_reg};
          `OFF_CTRL: rdata <= {8'h00, ctrl_reg};
          default: rdata <= 16'h0000;
        endcase
      end else
        rdata <= 16'h0000;
    end
  end

  // The interrupt is a level, high while any unmasked status bit is set.
  assign irq = |(status_reg & mask_reg);

endmodule // drive_fault_supervisor

// [tb/fault_sup_checker_sva.sv]
// Port checker for the drive fault supervisor.
// Assumes a bind onto the supervisor; one clock, synchronous active-low reset.
`timescale 1ns/1ns
module fault_sup_checker #(
  parameter POS_W = 32
) (
  input wire clk,
  input wire resetn,
  input wire stop_input,
  input wire drive_enable,
  input wire rms_foldback,
  input wire motion_req,
  input wire motion_en,
  input wire ready_dot,
  input wire bridge_disable,
  input wire all_segments,
  input wire limit_80,
  input wire [4:0] display_code,
  input wire [POS_W-1:0] position
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----
  // Properties
  // ----
  a_motion_gate: assert property (motion_en |-> motion_req && !bridge_disable)
    else $error("motion enabled without request or with bridge off");
  a_ready_enable: assert property (ready_dot |-> $past(drive_enable))
    else $error("ready dot lit while drive disabled");
  a_ready_stop: assert property (stop_input [*7] |-> !ready_dot)
    else $error("ready dot lit during stop");
  a_fold_limit: assert property (rms_foldback [*2] |-> limit_80)
    else $error("foldback without current limit");
  a_fault_shown: assert property (bridge_disable && $past(resetn, 2) |-> display_code[4])
    else $error("bridge off but no fault code shown");
  a_lamp_bridge: assert property (all_segments && $past(resetn, 2) |-> bridge_disable)
    else $error("bridge on during lamp test");
  a_travel_bridge: assert property (display_code == 5'h1d && !all_segments &&
    !$past(all_segments) |-> !bridge_disable)
    else $error("travel fault disabled the bridge");
  a_idle_bridge: assert property (!display_code[4] && $past(resetn, 2) |-> !bridge_disable)
    else $error("bridge off with status code shown");
  a_pos_step: assert property ($past(resetn) && position != $past(position) |->
    position - $past(position) == 1 || $past(position) - position == 1)
    else $error("position jumped by more than one count");
endmodule // fault_sup_checker

bind drive_fault_supervisor fault_sup_checker #(.POS_W(POS_W)) fault_sup_checker_inst (
  .clk(clk), .resetn(resetn), .stop_input(stop_input), .drive_enable(drive_enable),
  .rms_foldback(rms_foldback), .motion_req(motion_req), .motion_en(motion_en),
  .ready_dot(ready_dot), .bridge_disable(bridge_disable), .all_segments(all_segments),
  .limit_80(limit_80), .display_code(display_code), .position(position));

// [tb/reset_panel.sv]
// Model of the operator reset controls: front button and reset input line.
// Assumes the bench calls press from its own process, after a clock edge.
`timescale 1ns/1ns
module reset_panel (
  input wire clk,
  output logic reset_button,
  output logic reset_input
);
  initial begin
    reset_button = 1'b0;
    reset_input = 1'b0;
  end
  // ----
  // Press
  // ----
  // request held n cycles
  task automatic press(input int n, input logic line);
    @(posedge clk);
    if (line) begin
      reset_input <= 1'b1;
    end else begin
      reset_button <= 1'b1;
    end
    repeat (n) @(posedge clk);
    reset_button <= 1'b0;
    reset_input <= 1'b0;
  endtask
endmodule // reset_panel

// [tb/drive_fault_supervisor_tb_top.sv]
// Self-checking bench for the drive fault supervisor.
// Assumes the supervisor, its constants header and the reset panel model.
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module drive_fault_supervisor_tb_top;
  localparam logic [15:0] RES = 16'h1e72;
  logic clk = 0, resetn = 0, drive_enable = 0, stop_input = 0, rms_foldback = 0;
  logic stall_foldback = 0, brake_assigned = 0, brake_out_on = 0, motion_req = 0;
  logic enc_step = 0, enc_dir = 0, travel_neg = 0, wr = 0, rd = 0;
  logic [2:0] op_mode = 0;
  logic [3:0] addr = 0;
  logic [15:0] wdata = 0, flt = 0, rdata;
  logic [4:0] display_code;
  logic [31:0] position;
  logic ready_dot, motion_en, bridge_disable, all_segments, limit_80, irq;
  logic reset_button, reset_input;
  int failures = 0, n_compared = 0, cycles = 0;

  drive_fault_supervisor #(.LBUS_CYC(20), .CFG_HOLD_CYC(50), .ALLON_CYC(30))
    drive_fault_supervisor_inst (.clk(clk), .resetn(resetn), .ce(1'b1),
    .selftest_fail(flt[0]), .nvm_invalid(flt[1]), .drive_ovt(flt[2]), .module_seen(flt[3]),
    .pmod_flt(flt[4]), .high_bus(flt[5]), .low_bus(flt[6]), .enc_state_err(flt[7]),
    .enc_hw_err(flt[8]), .motor_ovt(flt[9]), .shunt_ovl(flt[10]), .overspeed(flt[11]),
    .follow_err(flt[12]), .travel_pos(flt[13]), .travel_neg(travel_neg),
    .reset_button(reset_button), .reset_input(reset_input), .drive_enable(drive_enable),
    .stop_input(stop_input), .op_mode(op_mode), .rms_foldback(rms_foldback),
    .stall_foldback(stall_foldback), .brake_assigned(brake_assigned),
    .brake_out_on(brake_out_on), .motion_req(motion_req), .enc_step(enc_step),
    .enc_dir(enc_dir), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .display_code(display_code), .ready_dot(ready_dot), .motion_en(motion_en),
    .bridge_disable(bridge_disable), .all_segments(all_segments), .limit_80(limit_80),
    .position(position), .irq(irq));
  reset_panel reset_panel_inst (.clk(clk), .reset_button(reset_button),
    .reset_input(reset_input));

  initial begin
    forever #5 clk = ~clk;
  end
  // ----
  // Helpers
  // ----
  task w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task pwr;
    @(posedge clk);
    resetn <= 0;
    repeat (8) @(posedge clk);
    resetn <= 1;
  endtask
  task wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1;
    `CHK(rdata, e)
  endtask
  task step(input logic d);
    @(posedge clk);
    enc_dir <= d;
    @(posedge clk);
    enc_step <= 1;
    repeat (4) @(posedge clk);
    enc_step <= 0;
    repeat (4) @(posedge clk);
  endtask
  task test_done;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task t_lamp;
    pwr;
    w(3);
    `CHK({all_segments, bridge_disable, display_code}, 7'h7e)
    w(40);
    `CHK({all_segments, display_code}, 6'h01)
  endtask
  task t_status;
    @(posedge clk);
    drive_enable <= 1;
    motion_req <= 1;
    for (int m = 0; m < 4; m++) begin
      op_mode <= m[2:0];
      w(3);
      `CHK(display_code, 5'h02 + m[4:0])
    end
    `CHK({ready_dot, motion_en}, 2'b11)
    stop_input <= 1;
    w(8);
    `CHK({ready_dot, motion_en}, 2'b00)
    stop_input <= 0;
    rms_foldback <= 1;
    w(3);
    `CHK({limit_80, display_code}, 6'h26)
    rms_foldback <= 0;
    stall_foldback <= 1;
    w(3);
    `CHK({limit_80, display_code}, 6'h27)
    stall_foldback <= 0;
    brake_assigned <= 1;
    w(8);
    `CHK(display_code, 5'h08)
    brake_out_on <= 1;
    w(8);
    `CHK(display_code, 5'h05)
    brake_assigned <= 0;
    drive_enable <= 0;
    flt <= 16'h0040;
    repeat (10) @(posedge clk);
    flt <= 0;
    w(40);
    `CHK(display_code, 5'h01)
    travel_neg <= 1;
    w(10);
    `CHK({bridge_disable, display_code}, 6'h1d)
    travel_neg <= 0;
    w(10);
    `CHK(display_code, 5'h01)
  endtask
  task t_faults;
    logic [4:0] e;
    for (int i = 0; i < 14; i++) begin
      e = 5'h10 + i[4:0];
      @(posedge clk);
      flt <= (16'h1 << i) | (i < 12 ? 16'h1000 : 16'h0000);
      w(40);
      `CHK({bridge_disable, display_code}, {i != 13, e})
      flt <= 0;
      w(10);
      if (i == 13) begin
        `CHK(display_code, 5'h01)
      end else begin
        `CHK(display_code, e)
        reset_panel_inst.press(3, i[0]);
        w(10);
        `CHK(display_code, RES[i] ? 5'h01 : e)
        if (i == 3) begin
          reset_panel_inst.press(60, 1'b0);
        end else if (!RES[i]) begin
          pwr;
        end
        w(45);
        `CHK(display_code, 5'h01)
      end
    end
  endtask
  task t_regs;
    rd_chk(4'h1, 16'h0000);
    rd_chk(4'h3, 16'h0000);
    wr_reg(4'h3, 16'h00a5);
    rd_chk(4'h3, 16'h00a5);
    rd_chk(4'h9, 16'h0000);
    wr_reg(4'h0, 16'hffff);
    wr_reg(4'h1, 16'h1000);
    @(posedge clk);
    flt <= 16'h1000;
    w(20);
    rd_chk(4'h2, 16'h1000);
    rd_chk(4'h0, 16'h1000);
    step(0);
    step(0);
    step(0);
    step(1);
    w(8);
    `CHK({bridge_disable, position}, 33'h100000002)
    wr_reg(4'h1, 16'h0000);
    w(2);
    `CHK(irq, 1'b0)
    wr_reg(4'h1, 16'h1000);
    w(2);
    `CHK(irq, 1'b1)
    flt <= 0;
    reset_panel_inst.press(3, 1'b0);
    w(10);
    `CHK(irq, 1'b1)
    wr_reg(4'h0, 16'h1000);
    w(2);
    `CHK(irq, 1'b0)
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      test_done;
    end
  end
  initial begin
    t_lamp;
    t_status;
    t_faults;
    t_regs;
    test_done;
  end
endmodule // drive_fault_supervisor_tb_top
